// file: fsp_sync_port.sv
// Framer-side serial TDM port group in the synchronous and echo modes.
// Assumes configuration levels come from the system clock domain and
// the framers share the reference clock, which runs free.
//
// Overview of operation
// - All ports clocked from reference clock only.
// - Global sync uses begin input 0 only.
// - Per-port sync uses each port's begin input.
// - Pins released only after transmit activate set.
// - Mode field 11 selects low-rate aligned mode.
// - Low rate: receive edge falling/0, rising/1.
// - Low rate: transmit edge rising/0, falling/1.
// - Begin input sampled on opposite edge.
// - Structured uses begin pulses; unstructured ignores them.
// - Begin polarity bit: 0 low, 1 high.
// - Mode field 10 selects high-rate aligned mode.
// - High/echo: receive sampled mid-bit on falling edge.
// - High/echo: transmit launched on falling edges.
// - Echo mode when mode pin low.
// - Echo: even transmit aligned, odd lanes shifted.
// - Echo: frame sync 0 marks first bit.
// - Frame of 32 slots, slot 0, MSB first.
// - High rate: each bit four clocks.
// - Line channel n maps to slot n.
module fsp_sync_port
  import fsp_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic       ref_clk_in,
  input  wire logic [1:0] op_mode_field_in,
  input  wire logic       echo_cancel_mode_pin_b_in,
  input  wire logic       port_sync_sel_in,
  input  wire logic       rx_edge_sel_in,
  input  wire logic       mframe_pol_in,
  input  wire logic [7:0] port_unstructured_in,
  input  wire logic [7:0] port_tx_act_in,
  input  wire logic [7:0] port_rx_clk_in,
  input  wire logic [7:0] port_rx_frame_pulse_in,
  input  wire logic [7:0] port_rx_serial_in,
  input  wire logic [7:0] port_mframe_begin_in,
  input  wire logic [7:0] tx_byte_in,
  output logic [7:0]      rx_byte_out,
  output logic [4:0]      rx_slot_out,
  output logic [7:0]      rx_byte_valid_out,
  output logic [4:0]      tx_slot_out,
  output logic [7:0]      mframe_seen_out,
  output logic            sync_active_out,
  output logic [7:0]      port_tx_serial_out,
  output logic [7:0]      port_tx_serial_oe_b_out,
  output logic [7:0]      port_tx_frame_sync_out,
  output logic [7:0]      port_tx_frame_sync_oe_b_out,
  output logic [7:0]      port_tx_clk_oe_b_out,
  output logic [7:0]      port_tx_mframe_sync_oe_b_out
);
  import fsp_pkg::*;

  // ------------------------------------------------------------------
  // Configuration crossing into the reference domain
  // ------------------------------------------------------------------
  // Static levels; two flops each, first flop read only by the second
  localparam int unsigned CFG_W = 30;
  logic [CFG_W-1:0] cfg_meta_reg;
  logic [CFG_W-1:0] cfg_sync_reg;
  logic [1:0]       mode_r;
  logic             ec_b_r;
  logic             psel_r;
  logic             redge_r;
  logic             pol_r;
  logic [7:0]       unstr_r;
  logic [7:0]       act_r;
  logic [7:0]       txb_r;
  logic             rst_meta_reg;
  logic             rst_ref_b_reg;

  always_ff @(posedge ref_clk_in) begin
    rst_meta_reg  <= rst_b_in;
    rst_ref_b_reg <= rst_meta_reg;
    cfg_meta_reg  <= {op_mode_field_in, echo_cancel_mode_pin_b_in,
                      port_sync_sel_in, rx_edge_sel_in, mframe_pol_in,
                      port_unstructured_in, port_tx_act_in, tx_byte_in};
    cfg_sync_reg  <= cfg_meta_reg;
  end

  assign {mode_r, ec_b_r, psel_r, redge_r, pol_r, unstr_r, act_r, txb_r}
    = cfg_sync_reg;

  // Echo pin wins over the mode field
  fsp_mode_e mode;
  always_comb begin
    if (!ec_b_r) begin
      mode = FSP_ECHO;
    end else if (mode_r == MODE_SYNC_LOW) begin
      mode = FSP_LOW;
    end else if (mode_r == MODE_SYNC_HIGH) begin
      mode = FSP_HIGH;
    end else begin
      mode = FSP_OFF;
    end
  end

  logic hi_rate;
  assign hi_rate = (mode == FSP_HIGH) || (mode == FSP_ECHO);

  // ------------------------------------------------------------------
  // Pin sampling on both reference edges
  // ------------------------------------------------------------------
  // Pins are synchronous to the reference clock, so they are caught on
  // the documented edge directly; a two-flop stage would add latency
  // that breaks slot alignment.
  logic [7:0] rx_rise_reg;
  logic [7:0] rx_fall_reg;
  logic [7:0] mfb_rise_reg;
  logic [7:0] mfb_fall_reg;

  // Falling-edge capture; data is read straight from it (half-cycle
  // path) so it stays in step with the count, begin is retimed below
  always_ff @(negedge ref_clk_in) begin
    rx_fall_reg  <= port_rx_serial_in;
    mfb_fall_reg <= port_mframe_begin_in;
  end

  logic [7:0] mfb_fall_rt_reg;
  always_ff @(posedge ref_clk_in) begin
    rx_rise_reg     <= port_rx_serial_in;
    mfb_rise_reg    <= port_mframe_begin_in;
    mfb_fall_rt_reg <= mfb_fall_reg;
  end

  // Data edge from the select bit at low rate, falling at high/echo; begin uses the opposite edge
  logic       rx_on_rise;
  logic [7:0] rx_bit;
  logic [7:0] mfb_raw;
  logic [7:0] mfb_act;
  assign rx_on_rise = (mode == FSP_LOW) && redge_r;
  assign rx_bit  = rx_on_rise ? rx_rise_reg : rx_fall_reg;
  assign mfb_raw = rx_on_rise ? mfb_fall_rt_reg : mfb_rise_reg;
  assign mfb_act = pol_r ? mfb_raw : ~mfb_raw;

  // Per-port begin source: global input 0 or own input
  logic [7:0] mfb_sel;
  logic [7:0] mfb_prev_reg;
  logic [7:0] mfb_edge;
  assign mfb_sel = psel_r ? mfb_act : {8{mfb_act[0]}};
  assign mfb_edge = mfb_sel & ~mfb_prev_reg & ~unstr_r
                    & {8{mode != FSP_ECHO}};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_ref_b_reg) begin
      mfb_prev_reg <= 8'h00;
    end else begin
      mfb_prev_reg <= mfb_sel;
    end
  end

  // ------------------------------------------------------------------
  // Frame counters, one per port
  // ------------------------------------------------------------------
  // A begin pulse realigns the count to bit 0 of slot 0
  function automatic fsp_cnt_t next_cnt(input fsp_cnt_t c,
                                        input logic hi);
    fsp_cnt_t last;
    last = hi ? FRAME_LAST_HI : FRAME_LAST_LO;
    next_cnt = (c >= last) ? '0 : fsp_cnt_t'(c + 1'b1);
  endfunction

  fsp_cnt_t cnt_reg [NUM_PORTS];
  always_ff @(posedge ref_clk_in) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!rst_ref_b_reg || mode == FSP_OFF) begin
        cnt_reg[p] <= '0;
      end else if (mfb_edge[p]) begin
        cnt_reg[p] <= fsp_cnt_t'(1);
      end else if (mode == FSP_ECHO && p != 0) begin
        cnt_reg[p] <= next_cnt(cnt_reg[0], hi_rate);
      end else begin
        cnt_reg[p] <= next_cnt(cnt_reg[p], hi_rate);
      end
    end
  end

  // Bit phase within a slot: four clocks per bit at high rate
  function automatic logic [1:0] phase_of(input fsp_cnt_t c,
                                          input logic hi);
    phase_of = hi ? c[1:0] : 2'h0;
  endfunction

  function automatic logic [2:0] bit_of(input fsp_cnt_t c,
                                        input logic hi);
    bit_of = hi ? c[4:2] : c[2:0];
  endfunction

  function automatic logic [4:0] slot_of(input fsp_cnt_t c,
                                         input logic hi);
    slot_of = hi ? c[9:5] : c[7:3];
  endfunction

  // ------------------------------------------------------------------
  // Receive shift, MSB first
  // ------------------------------------------------------------------
  fsp_byte_t shf_reg [NUM_PORTS];
  logic [7:0] done;
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      done[p] = (phase_of(cnt_reg[p], hi_rate) == 2'(SAMPLE_PHASE)
                 || !hi_rate)
                && bit_of(cnt_reg[p], hi_rate) == 3'h7;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!hi_rate ||
          phase_of(cnt_reg[p], hi_rate) == 2'(SAMPLE_PHASE)) begin
        shf_reg[p] <= {shf_reg[p][6:0], rx_bit[p]};
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit launch
  // ------------------------------------------------------------------
  // Launch edge: falling in high/echo, else from select bit
  logic tx_on_fall;
  assign tx_on_fall = hi_rate || redge_r;

  logic [7:0] tx_next;
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      tx_next[p] = txb_r[3'(7) - bit_of(cnt_reg[p], hi_rate)];
    end
  end

  logic [7:0] tx_rise_reg;
  logic [7:0] tx_fall_reg;
  logic       fs_rise_reg;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_ref_b_reg) begin
      tx_rise_reg <= 8'h00;
      fs_rise_reg <= 1'b0;
    end else begin
      tx_rise_reg <= tx_next;
      fs_rise_reg <= (mode == FSP_ECHO) && cnt_reg[0] < fsp_cnt_t'(4);
    end
  end

  always_ff @(negedge ref_clk_in) begin
    if (!rst_ref_b_reg) begin
      tx_fall_reg            <= 8'h00;
      port_tx_frame_sync_out <= 8'h00;
    end else begin
      tx_fall_reg            <= tx_rise_reg;
      port_tx_frame_sync_out <= {7'h00, fs_rise_reg};
    end
  end

  // Odd lanes in echo mode trail the even lanes
  logic [7:0] odd_dly_reg [ODD_TX_SHIFT];
  always_ff @(posedge ref_clk_in) begin
    odd_dly_reg[0] <= tx_fall_reg;
    for (int i = 1; i < ODD_TX_SHIFT; i++) begin
      odd_dly_reg[i] <= odd_dly_reg[i-1];
    end
  end

  // Pin drivers: one flop per launch edge, picked by the static mode,
  // so falling-edge modes never change the pin on a rising edge
  logic [7:0] tx_pin_rise_reg;
  logic [7:0] tx_pin_fall_reg;
  always_ff @(posedge ref_clk_in) begin
    tx_pin_rise_reg <= tx_rise_reg;
  end

  always_ff @(negedge ref_clk_in) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (mode == FSP_ECHO && p[0]) begin
        tx_pin_fall_reg[p] <= odd_dly_reg[ODD_TX_SHIFT-1][p];
      end else begin
        tx_pin_fall_reg[p] <= tx_rise_reg[p];
      end
    end
  end

  assign port_tx_serial_out = tx_on_fall ? tx_pin_fall_reg
                                         : tx_pin_rise_reg;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_ref_b_reg) begin
      port_tx_serial_oe_b_out     <= OE_B_RST;
      port_tx_frame_sync_oe_b_out <= OE_B_RST;
    end else begin
      port_tx_serial_oe_b_out <= ~(act_r & {8{mode != FSP_OFF}});
      port_tx_frame_sync_oe_b_out <=
        {7'h7f, ~(act_r[0] && mode == FSP_ECHO)};
    end
  end

  // ------------------------------------------------------------------
  // Unused pins: clocks and multiframe syncs never driven
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    port_tx_clk_oe_b_out         <= OE_B_RST;
    port_tx_mframe_sync_oe_b_out <= OE_B_RST;
  end

  // ------------------------------------------------------------------
  // Status toward the system clock domain
  // ------------------------------------------------------------------
  // Bytes are held long enough (a slot) for a level crossing; the
  // valid lanes toggle per byte and are edge-detected on clock_in.
  logic [7:0] tog_reg;
  fsp_byte_t  hold_reg;
  logic [4:0] slot_hold_reg;
  logic [4:0] txs_hold_reg;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_ref_b_reg) begin
      tog_reg       <= 8'h00;
      hold_reg      <= 8'h00;
      slot_hold_reg <= 5'h00;
      txs_hold_reg  <= 5'h00;
    end else begin
      tog_reg <= tog_reg ^ done;
      txs_hold_reg <= slot_of(cnt_reg[0], hi_rate);
      if (done[0]) begin
        hold_reg      <= {shf_reg[0][6:0], rx_bit[0]};
        slot_hold_reg <= slot_of(cnt_reg[0], hi_rate);
      end
    end
  end

  logic [7:0] tog_meta_reg;
  logic [7:0] tog_sync_reg;
  logic [7:0] tog_prev_reg;
  logic [7:0] mf_meta_reg;
  logic [7:0] mf_sync_reg;
  logic [17:0] st_meta_reg;
  logic [17:0] st_sync_reg;
  always_ff @(posedge clock_in) begin
    tog_meta_reg <= tog_reg;
    tog_sync_reg <= tog_meta_reg;
    mf_meta_reg  <= mfb_prev_reg;
    mf_sync_reg  <= mf_meta_reg;
    st_meta_reg  <= {hold_reg, slot_hold_reg, txs_hold_reg};
    st_sync_reg  <= st_meta_reg;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      tog_prev_reg      <= 8'h00;
      rx_byte_valid_out <= 8'h00;
      rx_byte_out       <= 8'h00;
      rx_slot_out       <= 5'h00;
      tx_slot_out       <= 5'h00;
      mframe_seen_out   <= 8'h00;
      sync_active_out   <= 1'b0;
    end else begin
      tog_prev_reg      <= tog_sync_reg;
      rx_byte_valid_out <= tog_sync_reg ^ tog_prev_reg;
      rx_byte_out       <= st_sync_reg[17:10];
      rx_slot_out       <= st_sync_reg[9:5];
      tx_slot_out       <= st_sync_reg[4:0];
      mframe_seen_out   <= mf_sync_reg;
      sync_active_out   <= (op_mode_field_in[1] ||
                            !echo_cancel_mode_pin_b_in);
    end
  end

endmodule

// file: fsp_pkg.sv
// Package for the synchronous framer port block: modes, frame timing,
// reset values and mode field encodings.
// Assumes one framer port group of eight serial lanes on a reference clock.
package fsp_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int unsigned NUM_PORTS      = 8;
  localparam int unsigned SLOTS_PER_FRM  = 32;
  localparam int unsigned BITS_PER_SLOT  = 8;
  localparam int unsigned BITS_PER_FRM   = SLOTS_PER_FRM * BITS_PER_SLOT;
  localparam int unsigned FRAME_TIME_US  = 125;
  localparam int unsigned CLKS_PER_BIT_HI = 4;
  localparam int unsigned CLKS_PER_BIT_LO = 1;
  localparam int unsigned FRAME_CLKS_HI  = BITS_PER_FRM * CLKS_PER_BIT_HI;
  localparam int unsigned FRAME_CLKS_LO  = BITS_PER_FRM * CLKS_PER_BIT_LO;
  localparam int unsigned SAMPLE_PHASE   = 2;   // Middle of a 4-clock bit
  localparam int unsigned LAUNCH_PHASE   = 0;   // First clock of a bit
  localparam int unsigned ODD_TX_SHIFT   = 4;   // Odd lane offset, clocks

  typedef logic [9:0] fsp_cnt_t;               // Up to 1024 clocks/frame
  typedef logic [7:0] fsp_byte_t;

  localparam fsp_cnt_t FRAME_LAST_HI = fsp_cnt_t'(FRAME_CLKS_HI - 1);
  localparam fsp_cnt_t FRAME_LAST_LO = fsp_cnt_t'(FRAME_CLKS_LO - 1);

  // ------------------------------------------------------------------
  // Mode field encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_SYNC_HIGH = 2'h2;  // 8.192 MHz
  localparam logic [1:0] MODE_SYNC_LOW  = 2'h3;  // 2.048 MHz

  typedef enum logic [1:0] {
    FSP_OFF  = 2'b00,
    FSP_LOW  = 2'b01,
    FSP_HIGH = 2'b11,
    FSP_ECHO = 2'b10
  } fsp_mode_e;

  // Reset values
  localparam logic [7:0] TX_ACT_RST  = 8'h00;
  localparam logic [7:0] OE_B_RST    = 8'hff;

endpackage

// file: fsp_sync_port_asserts.sv
// Checker for the framer port group, bound to its top module.
// Assumes the reference clock runs free and config changes are rare.
module fsp_sync_port_asserts
  import fsp_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  input wire logic       ref_clk_in,
  input wire logic [1:0] op_mode_field_in,
  input wire logic       echo_cancel_mode_pin_b_in,
  input wire logic       rx_edge_sel_in,
  input wire logic [7:0] port_tx_act_in,
  input wire logic [7:0] rx_byte_valid_out,
  input wire logic       sync_active_out,
  input wire logic [7:0] port_tx_serial_out,
  input wire logic [7:0] port_tx_serial_oe_b_out,
  input wire logic [7:0] port_tx_frame_sync_out,
  input wire logic [7:0] port_tx_frame_sync_oe_b_out,
  input wire logic [7:0] port_tx_clk_oe_b_out,
  input wire logic [7:0] port_tx_mframe_sync_oe_b_out
);
  // ------------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------------
  logic [3:0]  cfg_prev_reg;
  logic [3:0]  cfg_age_reg;
  logic [7:0]  tx_pos_reg;
  logic        fs_prev_reg;
  logic [10:0] fs_cnt_reg;
  wire  [3:0]  cfg_now = {op_mode_field_in, echo_cancel_mode_pin_b_in,
                          rx_edge_sel_in};
  wire         fall_mode = (cfg_age_reg == 4'hf) &&
                           (op_mode_field_in == MODE_SYNC_HIGH ||
                            !echo_cancel_mode_pin_b_in ||
                            (op_mode_field_in == MODE_SYNC_LOW &&
                             rx_edge_sel_in));
  wire         fs_rise = port_tx_frame_sync_out[0] && !fs_prev_reg;

  // Config age: the ref side lags a change, so skip that window
  always_ff @(posedge ref_clk_in) begin
    cfg_prev_reg <= cfg_now;
    if (!rst_b_in || cfg_now != cfg_prev_reg) begin
      cfg_age_reg <= 4'h0;
    end else if (cfg_age_reg != 4'hf) begin
      cfg_age_reg <= cfg_age_reg + 4'h1;
    end
  end

  // Tx levels as seen at each rising edge
  always_ff @(posedge ref_clk_in) begin
    tx_pos_reg <= port_tx_serial_out;
  end

  // Ref clocks since the last frame sync rise, 0 while none seen
  always_ff @(posedge ref_clk_in) begin
    fs_prev_reg <= port_tx_frame_sync_out[0];
    if (!rst_b_in) begin
      fs_cnt_reg <= 11'h000;
    end else if (fs_rise) begin
      fs_cnt_reg <= 11'h001;
    end else if (fs_cnt_reg != 11'h000 && fs_cnt_reg != 11'h7ff) begin
      fs_cnt_reg <= fs_cnt_reg + 11'h001;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  sequence s_fs_bit;
    port_tx_frame_sync_out[0] [*4] ##1 !port_tx_frame_sync_out[0];
  endsequence

  chk_unused_oe_idle: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) port_tx_clk_oe_b_out == 8'hff &&
    port_tx_mframe_sync_oe_b_out == 8'hff)
    else $error("unused clock or multiframe pin driven");
  chk_fs_upper_idle: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) port_tx_frame_sync_out[7:1] == 7'h00 &&
    port_tx_frame_sync_oe_b_out[7:1] == 7'h7f)
    else $error("frame sync 1 to 7 active");
  chk_oe_in_reset: assert property (@(posedge ref_clk_in)
    (!rst_b_in) [*6] |-> port_tx_serial_oe_b_out == 8'hff &&
    port_tx_frame_sync_oe_b_out == 8'hff)
    else $error("pins driven in reset");
  chk_oe_no_act: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) (port_tx_act_in == 8'h00) [*8] |->
    port_tx_serial_oe_b_out == 8'hff)
    else $error("tx driven while inactive");
  chk_mode_flag_track: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) ##1 sync_active_out ==
    $past(op_mode_field_in[1] | ~echo_cancel_mode_pin_b_in))
    else $error("sync flag wrong for mode");
  chk_valid_one_pulse: assert property (@(posedge clock_in)
    disable iff (!rst_b_in) rx_byte_valid_out[0] |=>
    !rx_byte_valid_out[0])
    else $error("byte valid longer than one clock");
  chk_fs_bit_width: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) $rose(port_tx_frame_sync_out[0]) |-> s_fs_bit)
    else $error("frame sync not one bit wide");
  chk_fs_frame_period: assert property (@(posedge ref_clk_in)
    disable iff (!rst_b_in) fs_rise && fs_cnt_reg != 11'h000 |->
    fs_cnt_reg == 11'h400)
    else $error("frame sync period not 1024 clocks");
  chk_tx_fall_launch: assert property (@(negedge ref_clk_in)
    disable iff (!rst_b_in) fall_mode |-> port_tx_serial_out == tx_pos_reg)
    else $error("tx changed on the wrong edge");
endmodule

bind fsp_sync_port fsp_sync_port_asserts fsp_sync_port_asserts_inst (
  .clock_in, .rst_b_in, .ref_clk_in, .op_mode_field_in,
  .echo_cancel_mode_pin_b_in, .rx_edge_sel_in, .port_tx_act_in,
  .rx_byte_valid_out, .sync_active_out, .port_tx_serial_out,
  .port_tx_serial_oe_b_out, .port_tx_frame_sync_out,
  .port_tx_frame_sync_oe_b_out, .port_tx_clk_oe_b_out,
  .port_tx_mframe_sync_oe_b_out);

// file: fsp_framer_model.sv
// Far-side framer: sends E1 frames on all rx lanes, marks frame start.
// Assumes its settings stay put while run_in is high.
module fsp_framer_model
  import fsp_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       run_in,
  input  wire logic       low_rate_in,
  input  wire logic       samp_rise_in,
  input  wire logic       pol_in,
  input  wire logic [7:0] begin_mask_in,
  input  wire logic [7:0] seed_in,
  output logic [7:0]      rx_serial_out,
  output logic [7:0]      mframe_begin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int        pos = -1;
  int        cpb;
  fsp_byte_t slot_byte;
  logic      beg;

  // Begin toggles on the data sample edge, so it is firm at the other
  // edge; low-rate data is inverted once its hold has run out
  always @(ref_clk_in) begin
    cpb = low_rate_in ? 1 : 4;
    #2;
    if (ref_clk_in != (low_rate_in && samp_rise_in)) begin
      pos = run_in ? (pos + 1) % (BITS_PER_FRM * cpb) : -1;
      slot_byte = fsp_byte_t'(pos / cpb / 8) ^ seed_in;
      if (pos < 0) begin
        rx_serial_out = ~rx_serial_out;
      end else if (pos % cpb == 0) begin
        rx_serial_out = {8{slot_byte[7 - (pos / cpb) % 8]}};
      end
    end else begin
      if (low_rate_in || pos < 0) begin
        rx_serial_out = ~rx_serial_out;
      end
      beg = run_in && (pos + 1) % (BITS_PER_FRM * cpb) < cpb;
      mframe_begin_out = {8{~pol_in}} ^ (begin_mask_in & {8{beg}});
    end
  end

  initial begin
    rx_serial_out = 8'h00;
    mframe_begin_out = 8'h00;
  end
endmodule

// file: tb.sv
// Self-checking bench for the framer port group in its sync modes.
// Assumes a 20 MHz system clock and a free 30 ns reference clock.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fsp_pkg::*;
  logic       clk = 1'b0;
  logic       rclk = 1'b0;
  logic       rst_b = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       ec_b = 1'b1;
  logic       psync = 1'b0;
  logic       esel = 1'b0;
  logic       pol = 1'b0;
  logic       run = 1'b0;
  logic       low = 1'b0;
  logic [7:0] unstr = 8'h00;
  logic [7:0] act = 8'h00;
  logic [7:0] txb = 8'h00;
  logic [7:0] mask = 8'h01;
  logic [7:0] seed = 8'h00;
  logic [7:0] rx_ser, mfb, rx_byte, rx_val, tx_ser, tx_oe_b, fs, fs_oe_b;
  logic [7:0] clk_oe_b, mfs_oe_b;
  logic [4:0] rx_slot;
  logic       sync_act;
  int         fail_count = 0;
  int         checks_done = 0;

  fsp_framer_model fsp_framer_model_inst (.ref_clk_in(rclk),
    .run_in(run), .low_rate_in(low), .samp_rise_in(esel), .pol_in(pol),
    .begin_mask_in(mask), .seed_in(seed), .rx_serial_out(rx_ser),
    .mframe_begin_out(mfb));

  fsp_sync_port fsp_sync_port_inst (.clock_in(clk), .rst_b_in(rst_b),
    .ref_clk_in(rclk), .op_mode_field_in(mode),
    .echo_cancel_mode_pin_b_in(ec_b), .port_sync_sel_in(psync),
    .rx_edge_sel_in(esel), .mframe_pol_in(pol),
    .port_unstructured_in(unstr), .port_tx_act_in(act),
    .port_rx_clk_in(8'h00), .port_rx_frame_pulse_in(8'h00),
    .port_rx_serial_in(rx_ser), .port_mframe_begin_in(mfb),
    .tx_byte_in(txb), .rx_byte_out(rx_byte), .rx_slot_out(rx_slot),
    .rx_byte_valid_out(rx_val), .tx_slot_out(), .mframe_seen_out(),
    .sync_active_out(sync_act), .port_tx_serial_out(tx_ser),
    .port_tx_serial_oe_b_out(tx_oe_b), .port_tx_frame_sync_out(fs),
    .port_tx_frame_sync_oe_b_out(fs_oe_b),
    .port_tx_clk_oe_b_out(clk_oe_b),
    .port_tx_mframe_sync_oe_b_out(mfs_oe_b));

  // Clocks, unrelated in phase
  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever #15 rclk = ~rclk;
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Receive run: a few frames to align, then 40 lane-0 bytes judged
  task automatic rx_run(input logic lr, es, pl, ps, input logic [7:0] mk,
                        input logic [7:0] sd);
    int n;
    @(negedge clk);
    mode = lr ? MODE_SYNC_LOW : MODE_SYNC_HIGH;
    low = lr;
    esel = es;
    pol = pl;
    psync = ps;
    mask = mk;
    seed = sd;
    repeat (20) @(negedge clk);
    chk("sync flag", 8'h01, {7'h00, sync_act});
    run = 1'b1;
    repeat (1400) @(negedge clk);
    for (int k = 0; k < 40; k++) begin
      n = 0;
      while (rx_val[0] !== 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      chk("byte valid", 8'h01, {7'h00, rx_val[0]});
      chk("rx byte", 8'(rx_slot) ^ sd, rx_byte);
      @(negedge clk);
    end
    run = 1'b0;
    $display("rx run low %b edge %b done", lr, es);
  endtask

  // Echo mode: frame sync marks bit 0 of slot 0, odd lane one bit late
  task automatic t_echo;
    logic [7:0] b0;
    logic [7:0] b1;
    int         n;
    @(negedge clk);
    ec_b = 1'b0;
    act = 8'h03;
    txb = 8'hb4;
    repeat (60) @(negedge clk);
    chk("tx oe", 8'hfc, tx_oe_b);
    chk("fs oe", 8'hfe, fs_oe_b);
    n = 0;
    while (fs[0] !== 1'b1 && n < 2000) begin
      @(posedge rclk);
      n++;
    end
    @(posedge rclk);
    for (int i = 0; i < 9; i++) begin
      if (i < 8) b0[7 - i] = tx_ser[0];
      if (i > 0) b1[8 - i] = tx_ser[1];
      repeat (4) @(posedge rclk);
    end
    chk("even lane", txb, b0);
    chk("odd lane", txb, b1);
    $display("echo test done");
  endtask

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("BAD watchdog expected done seen timeout");
    tally_and_finish();
  end

  initial begin
    repeat (20) @(negedge clk);
    chk("tx oe", 8'hff, tx_oe_b);
    chk("clk oe", 8'hff, clk_oe_b);
    chk("mfs oe", 8'hff, mfs_oe_b);
    chk("sync flag", 8'h00, {7'h00, sync_act});
    rst_b = 1'b1;
    $display("reset test done");
    rx_run(1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 8'h5a);
    rx_run(1'b1, 1'b0, 1'b1, 1'b1, 8'hff, 8'h3c);
    rx_run(1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 8'hc3);
    t_echo();
    tally_and_finish();
  end
endmodule
